// >>> cxf_pkg.sv
// Package of constants, register map and state types for the CAN transceiver control core.
package cxf_pkg;

    // -------------------------------------------------------------------
    // Timing and log FIFO size
    // -------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned DOM_TIMEOUT_US  = 1000;
    localparam int unsigned DOM_TIMEOUT_CYC = (DOM_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned FIFO_DEPTH      = 4;
    localparam int unsigned FIFO_WIDTH      = 8;

    // -------------------------------------------------------------------
    // Register map, byte addresses
    // -------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_EVENT  = 4'h8;
    localparam logic [3:0] ADDR_RXLOG  = 4'hC;

    localparam int unsigned CTRL_LISTEN_FORCE = 0;
    localparam int unsigned CTRL_TO_DISABLE   = 1;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

    localparam int unsigned EV_TIMEOUT = 0;
    localparam int unsigned EV_UV      = 1;
    localparam int unsigned EV_OT      = 2;
    localparam int unsigned EV_OVF     = 3;

    localparam logic [31:0] UNMAPPED_RD = 32'hDEAD_0000;

    // -------------------------------------------------------------------
    // Modes, Gray coded along off, active, listen
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        CXF_OFF    = 2'b00,
        CXF_ACTIVE = 2'b01,
        CXF_LISTEN = 2'b11,
        CXF_FAULT  = 2'b10
    } cxf_mode_t;

endpackage

// >>> cxf_fifo.sv
// Small valid/ready FIFO that buffers received bus-level samples for software.
`timescale 1ns/1ps
module cxf_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW+1)'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    chk_fifo_no_overfill: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// >>> cxf_core.sv
// Control core of a high-speed CAN transceiver: modes, driver command, receive output and fail-safes.
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cxf_core
    import cxf_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = DOM_TIMEOUT_CYC,
    parameter int unsigned SYNC_STAGES = 2
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Protocol controller side; pin pulls are resolved by the pad, undriven TXD arrives high.
    input  wire logic        txd_i,
    input  wire logic        mode_sel_i,
    input  wire logic        pwr_en_i,
    output logic             rxd_o,
    output logic             rxd_oe_o,
    // Analog front end.
    input  wire logic        bus_dominant_i,
    input  wire logic        vcc_low_i,
    input  wire logic        io_supply_low_level_i,
    input  wire logic        over_temp_i,
    output logic             drv_dominant_o,
    output logic             drv_enable_o,
    output logic             rx_enable_o,
    // Avalon-MM slave.
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o
);
    // -------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------
    // Reset values follow the safe pin defaults: TXD recessive, S and EN low.
    logic [SYNC_STAGES-1:0] txd_sync;
    logic [SYNC_STAGES-1:0] sel_sync;
    logic [SYNC_STAGES-1:0] en_sync;
    logic                   txd_s;
    logic                   sel_s;
    logic                   en_s;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            txd_sync <= '1;
            sel_sync <= '0;
            en_sync  <= '0;
        end else begin
            txd_sync <= {txd_sync[SYNC_STAGES-2:0], txd_i};
            sel_sync <= {sel_sync[SYNC_STAGES-2:0], mode_sel_i};
            en_sync  <= {en_sync[SYNC_STAGES-2:0], pwr_en_i};
        end
    end

    assign txd_s = txd_sync[SYNC_STAGES-1];
    assign sel_s = sel_sync[SYNC_STAGES-1];
    assign en_s  = en_sync[SYNC_STAGES-1];

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [3:0]  events;
    logic [3:0]  next_events;
    logic        ack;
    logic        next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    // -------------------------------------------------------------------
    // Mode and fail-safe state
    // -------------------------------------------------------------------
    cxf_mode_t   mode;
    cxf_mode_t   next_mode;
    logic [31:0] dom_cnt;
    logic [31:0] next_dom_cnt;
    logic        to_trip;
    logic        next_to_trip;
    logic        ot_latch;
    logic        next_ot_latch;
    logic        txd_prev;
    logic        uv;
    logic        to_en;

    assign uv    = vcc_low_i || io_supply_low_level_i;
    assign to_en = !ctrl[CTRL_TO_DISABLE];

    function automatic cxf_mode_t pick_mode(input logic en, input logic sel, input logic low, input logic frc);
        if (low) begin
            pick_mode = CXF_FAULT;
        end else if (!en) begin
            pick_mode = CXF_OFF;
        end else if (sel || frc) begin
            pick_mode = CXF_LISTEN;
        end else begin
            pick_mode = CXF_ACTIVE;
        end
    endfunction

    always_comb begin
        next_mode     = pick_mode(en_s, sel_s, uv, ctrl[CTRL_LISTEN_FORCE]);
        next_dom_cnt  = dom_cnt;
        next_to_trip  = to_trip;
        next_ot_latch = ot_latch;
        if (txd_s) begin
            next_dom_cnt = '0;
            next_to_trip = 1'b0;
        end else if (txd_prev) begin
            next_dom_cnt = 32'd1;
        end else if (dom_cnt < TIMEOUT_CYC) begin
            next_dom_cnt = dom_cnt + 32'd1;
        end else if (to_en) begin
            next_to_trip = 1'b1;
        end
        if (over_temp_i) begin
            next_ot_latch = 1'b1;
        end else if (txd_s) begin
            next_ot_latch = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode     <= CXF_OFF;
            dom_cnt  <= '0;
            to_trip  <= 1'b0;
            ot_latch <= 1'b0;
            txd_prev <= 1'b1;
        end else begin
            mode     <= next_mode;
            dom_cnt  <= next_dom_cnt;
            to_trip  <= next_to_trip;
            ot_latch <= next_ot_latch;
            txd_prev <= txd_s;
        end
    end

    // -------------------------------------------------------------------
    // Pin outputs
    // -------------------------------------------------------------------
    logic next_drv_dom;
    logic next_drv_en;
    logic next_rx_en;
    logic next_rxd;

    always_comb begin
        next_rx_en   = (mode == CXF_ACTIVE) || (mode == CXF_LISTEN);
        next_drv_en  = next_rx_en && !ot_latch;
        // Mode lags the synchronised pins by one flop, so the next mode gates the driver as well;
        // otherwise a change of mode select together with transmit data leaks one dominant cycle.
        next_drv_dom = (mode == CXF_ACTIVE) && (next_mode == CXF_ACTIVE)
                       && !txd_s && !to_trip && !ot_latch;
        next_rxd     = next_rx_en ? !bus_dominant_i : 1'b1;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            drv_dominant_o <= 1'b0;
            drv_enable_o   <= 1'b0;
            rx_enable_o    <= 1'b0;
            rxd_oe_o       <= 1'b0;
            rxd_o          <= 1'b1;
        end else begin
            drv_dominant_o <= next_drv_dom;
            drv_enable_o   <= next_drv_en;
            rx_enable_o    <= next_rx_en;
            rxd_oe_o       <= next_rx_en;
            rxd_o          <= next_rxd;
        end
    end

    // -------------------------------------------------------------------
    // Receive log FIFO
    // -------------------------------------------------------------------
    // Each change of receive level while receive is enabled is logged; a full FIFO drops the sample and flags an overflow.
    logic                  log_valid;
    logic                  log_ready;
    logic [FIFO_WIDTH-1:0] log_data;
    logic                  log_out_valid;
    logic                  log_pop;
    logic [FIFO_WIDTH-1:0] log_out_data;
    logic                  rxd_prev;

    assign log_valid = next_rx_en && (next_rxd != rxd_prev);
    assign log_data  = FIFO_WIDTH'({mode, to_trip, ot_latch, next_rxd});
    assign log_pop   = ack && avs_read_i && (avs_address_i == ADDR_RXLOG);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rxd_prev <= 1'b1;
        end else begin
            rxd_prev <= next_rxd;
        end
    end

    cxf_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_log (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (log_valid),
        .in_ready_o  (log_ready),
        .in_data_i   (log_data),
        .out_valid_o (log_out_valid),
        .out_ready_i (log_pop),
        .out_data_o  (log_out_data)
    );

    // -------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, answer at the second edge
    // -------------------------------------------------------------------
    logic [3:0] hw_ev;
    logic       req;

    assign req   = (avs_read_i || avs_write_i) && !ack;
    assign hw_ev = {log_valid && !log_ready, ot_latch, uv, to_trip};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    always_comb begin
        next_ack    = req;
        next_ctrl   = ctrl;
        next_events = events;
        next_rdata  = rdata;
        if (ack && avs_write_i && avs_address_i == ADDR_CTRL) begin
            next_ctrl = merge(ctrl, avs_writedata_i, avs_byteenable_i) & 32'h0000_0003;
        end
        if (ack && avs_write_i && avs_address_i == ADDR_EVENT && avs_byteenable_i[0]) begin
            next_events = events & ~avs_writedata_i[3:0];
        end
        next_events = next_events | hw_ev; // Set wins over clear.
        if (req && avs_read_i) begin
            case (avs_address_i)
                ADDR_CTRL:   next_rdata = ctrl;
                ADDR_STATUS: next_rdata = {24'h00_0000, 1'b0, log_out_valid, uv, over_temp_i,
                                           to_trip, ot_latch, mode};
                ADDR_EVENT:  next_rdata = {28'h000_0000, events};
                ADDR_RXLOG:  next_rdata = {23'h00_0000, log_out_valid, log_out_data};
                default:     next_rdata = UNMAPPED_RD;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ack    <= 1'b0;
            ctrl   <= CTRL_RESET;
            events <= '0;
            rdata  <= '0;
        end else begin
            ack    <= next_ack;
            ctrl   <= next_ctrl;
            events <= next_events;
            rdata  <= next_rdata;
        end
    end

    // Waitrequest is high by default so a request always sees one wait cycle.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= '0;
        end else begin
            avs_waitrequest_o <= !next_ack;
            avs_readdata_o    <= next_rdata;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    chk_listen_recessive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        mode == CXF_LISTEN |=> !drv_dominant_o) else $error("dominant driven in listen-only");
    chk_listen_entry: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        en_s && (sel_s || ctrl[CTRL_LISTEN_FORCE]) |=> !drv_dominant_o)
        else $error("dominant driven on entry to listen-only");
    chk_off_floats: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        mode == CXF_OFF |=> !rxd_oe_o && !drv_enable_o) else $error("outputs driven in off mode");
    chk_uv_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        uv |=> ##1 !drv_enable_o && !rx_enable_o) else $error("undervoltage did not switch off");
    chk_active_drive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        mode == CXF_ACTIVE && next_mode == CXF_ACTIVE && !txd_s && !to_trip && !ot_latch |=> drv_dominant_o)
        else $error("active mode failed to drive dominant");
    chk_rxd_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (mode == CXF_ACTIVE || mode == CXF_LISTEN) |=> rxd_o == !$past(bus_dominant_i))
        else $error("receive output does not follow bus");
    chk_timeout_trip: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        to_en && !txd_s && dom_cnt == TIMEOUT_CYC && $stable(ctrl) |=> to_trip)
        else $error("timeout did not trip");
    chk_timer_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        txd_s |=> dom_cnt == 0 && !to_trip) else $error("timer not cleared on recessive");
    chk_timer_start: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        txd_prev && !txd_s |=> dom_cnt == 1) else $error("timer not started");
    chk_ot_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        over_temp_i |=> ot_latch ##1 !drv_enable_o) else $error("overtemperature did not cut drivers");
    chk_bus_ack: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        req |=> !avs_waitrequest_o) else $error("bus answer late");

    cov_timeout: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $rose(to_trip));
    cov_listen: cover property (@(posedge mclk_i) disable iff (sys_rst_i) mode == CXF_LISTEN);
    cov_ot_recover: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $fell(ot_latch));
    cov_log_full: cover property (@(posedge mclk_i) disable iff (sys_rst_i) log_valid && !log_ready);
endmodule

// >>> cxf_ctrl_model.sv
// Behavioural model of the CAN protocol controller that drives the transceiver's logic pins.
`timescale 1ns/1ps
module cxf_ctrl_model (
    input  wire logic mclk_i,
    output logic      txd_o,
    output logic      mode_sel_o,
    output logic      pwr_en_o,
    output logic      pins_oe_o
);
    // -------------------------------------------------------------------
    // Pin driving
    // -------------------------------------------------------------------
    // The pins start released, so the pad pulls decide what the core sees at power-up.
    initial begin
        txd_o      = 1'b1;
        mode_sel_o = 1'b0;
        pwr_en_o   = 1'b0;
        pins_oe_o  = 1'b0;
    end

    task automatic set_pins(input logic txd, input logic sel, input logic en);
        @(posedge mclk_i);
        txd_o      <= txd;
        mode_sel_o <= sel;
        pwr_en_o   <= en;
        pins_oe_o  <= 1'b1;
    endtask

    task automatic release_pins();
        @(posedge mclk_i);
        pins_oe_o <= 1'b0;
    endtask

    // One frame bit; callers keep dominant bits far shorter than the timeout.
    task automatic send_bit(input logic b, input int cycles);
        @(posedge mclk_i);
        txd_o <= b;
        repeat (cycles - 1) @(posedge mclk_i);
    endtask
endmodule

// >>> can_transceiver_mode_failsafe_tb_top.sv
// Self-checking testbench for the CAN transceiver control core.
`timescale 1ns/1ps
module can_transceiver_mode_failsafe_tb_top;
    import cxf_pkg::*;
    // -------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        txd_m, sel_m, en_m, pins_oe, other_dom = 1'b0;
    logic        txd_i, mode_sel_i, pwr_en_i, bus_dominant_i;
    logic        rxd_o, rxd_oe_o, drv_dominant_o, drv_enable_o, rx_enable_o;
    logic        vcc_low_i = 1'b0, io_low_i = 1'b0, over_temp_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
    logic        avs_waitrequest_o;
    int          miscompares = 0, checks_done = 0;
    logic [7:0]  pat = 8'hA6;

    always #2.5 mclk_i = ~mclk_i;
    // Pad pulls: released transmit data reads recessive, mode and enable read low.
    assign txd_i      = pins_oe ? txd_m : 1'b1;
    assign mode_sel_i = pins_oe ? sel_m : 1'b0;
    assign pwr_en_i   = pins_oe ? en_m : 1'b0;
    assign bus_dominant_i = (drv_enable_o & drv_dominant_o) | other_dom;

    cxf_ctrl_model u_ctrl (.mclk_i(mclk_i), .txd_o(txd_m), .mode_sel_o(sel_m), .pwr_en_o(en_m), .pins_oe_o(pins_oe));

    cxf_core #(.TIMEOUT_CYC(20)) u_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .txd_i(txd_i), .mode_sel_i(mode_sel_i), .pwr_en_i(pwr_en_i),
        .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .bus_dominant_i(bus_dominant_i), .vcc_low_i(vcc_low_i),
        .io_supply_low_level_i(io_low_i), .over_temp_i(over_temp_i), .drv_dominant_o(drv_dominant_o),
        .drv_enable_o(drv_enable_o), .rx_enable_o(rx_enable_o), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request is held until waitrequest is sampled low; the answer is taken at that edge.
    // A slave that never answers is caught by the watchdog, not here.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        do begin
            @(posedge mclk_i);
        end while (avs_waitrequest_o !== 1'b0);
        r = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic settle();
        repeat (6) @(posedge mclk_i);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        check(drv_enable_o, 1'b0);
        check(rxd_o, 1'b1);
        bus(1'b0, ADDR_CTRL, 32'h0, q);
        check(q, CTRL_RESET);
        bus(1'b0, 4'h2, 32'h0, q);
        check(q, UNMAPPED_RD);
        settle();
        check(rxd_oe_o, 1'b0);
        check(drv_enable_o, 1'b0);
        done("reset");

        u_ctrl.set_pins(1'b1, 1'b0, 1'b1);
        settle();
        check(rxd_oe_o, 1'b1);
        check(drv_enable_o, 1'b1);
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        check(q[1:0], CXF_ACTIVE);
        for (int i = 0; i < 8; i++) begin
            u_ctrl.send_bit(pat[i], 8);
            check(drv_dominant_o, !pat[i]);
            check(rxd_o, pat[i]);
        end
        other_dom <= 1'b1;
        repeat (3) @(posedge mclk_i);
        check(rxd_o, 1'b0);
        other_dom <= 1'b0;
        done("active");

        u_ctrl.set_pins(1'b0, 1'b1, 1'b1);
        settle();
        check(drv_dominant_o, 1'b0);
        check(rxd_oe_o, 1'b1);
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        check(q[1:0], CXF_LISTEN);
        other_dom <= 1'b1;
        repeat (3) @(posedge mclk_i);
        check(rxd_o, 1'b0);
        other_dom <= 1'b0;
        repeat (3) @(posedge mclk_i);
        check(rxd_o, 1'b1);
        done("listen");

        // Transmit data stayed low through listen-only, too briefly to trip the timeout; go recessive first to restart the timer.
        u_ctrl.set_pins(1'b1, 1'b0, 1'b1);
        repeat (3) @(posedge mclk_i);
        u_ctrl.set_pins(1'b0, 1'b0, 1'b1);
        repeat (10) @(posedge mclk_i);
        check(drv_dominant_o, 1'b1);
        repeat (30) @(posedge mclk_i);
        check(drv_dominant_o, 1'b0);
        bus(1'b0, ADDR_EVENT, 32'h0, q);
        check(q[EV_TIMEOUT], 1'b1);
        u_ctrl.set_pins(1'b1, 1'b0, 1'b1);
        repeat (3) @(posedge mclk_i);
        u_ctrl.set_pins(1'b0, 1'b0, 1'b1);
        repeat (15) @(posedge mclk_i);
        check(drv_dominant_o, 1'b1);
        u_ctrl.set_pins(1'b1, 1'b0, 1'b1);
        done("timeout");

        vcc_low_i <= 1'b1;
        settle();
        check({drv_enable_o, rx_enable_o, rxd_oe_o}, 3'b000);
        vcc_low_i <= 1'b0;
        io_low_i  <= 1'b1;
        settle();
        check({drv_enable_o, rxd_oe_o}, 2'b00);
        io_low_i <= 1'b0;
        settle();
        check({drv_enable_o, rxd_oe_o}, 2'b11);
        done("undervoltage");

        u_ctrl.set_pins(1'b0, 1'b0, 1'b1);
        over_temp_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        check(drv_dominant_o, 1'b0);
        over_temp_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        check(drv_dominant_o, 1'b0);
        u_ctrl.set_pins(1'b1, 1'b0, 1'b1);
        repeat (2) @(posedge mclk_i);
        u_ctrl.set_pins(1'b0, 1'b0, 1'b1);
        settle();
        check(drv_dominant_o, 1'b1);
        done("overtemp");

        bus(1'b1, ADDR_CTRL, 32'h1, q);
        bus(1'b0, ADDR_CTRL, 32'h0, q);
        check(q, 32'h1);
        u_ctrl.set_pins(1'b1, 1'b0, 1'b1);
        u_ctrl.set_pins(1'b0, 1'b0, 1'b1);
        settle();
        check(drv_dominant_o, 1'b0);
        bus(1'b1, ADDR_CTRL, 32'h0, q);
        u_ctrl.set_pins(1'b1, 1'b0, 1'b1);
        done("control");

        // Drain the log, then fill it past its depth while software stalls.
        for (int i = 0; i < 40; i++) bus(1'b0, ADDR_RXLOG, 32'h0, q);
        check(q[8], 1'b0);
        bus(1'b1, ADDR_EVENT, 32'hF, q);
        for (int i = 0; i < 6; i++) begin
            other_dom <= ~other_dom;
            repeat (4) @(posedge mclk_i);
        end
        bus(1'b0, ADDR_EVENT, 32'h0, q);
        check(q[EV_OVF], 1'b1);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            bus(1'b0, ADDR_RXLOG, 32'h0, q);
            check(q[8], 1'b1);
            check(q[0], i[0]);
        end
        bus(1'b0, ADDR_RXLOG, 32'h0, q);
        check(q[8], 1'b0);
        done("log");

        // Released pins must take an active, dominant device off through the pad pulls.
        u_ctrl.set_pins(1'b0, 1'b0, 1'b1);
        settle();
        check(drv_dominant_o, 1'b1);
        u_ctrl.release_pins();
        settle();
        check({rxd_oe_o, drv_enable_o, drv_dominant_o}, 3'b000);
        u_ctrl.set_pins(1'b0, 1'b1, 1'b0);
        settle();
        check({drv_enable_o, drv_dominant_o, rxd_oe_o}, 3'b000);
        done("off");
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        tally_and_finish();
    end
endmodule
